// File: logic/pmx_defs.svh
// Notes on behaviour
// - Every output pin owns a register whose six low bits pick the internal source that drives the pin.
// - The two upper bits of each pin register are not implemented, read as zero and ignore writes.
// - The selection field clears on power-on and brown-out reset and keeps its value on every other reset.
// - Code 0x24 routes the second two-wire interface data output and code 0x23 its clock output.
// - Code 0x22 routes the first two-wire interface data output and code 0x21 its clock output.
// - While the remap lock flag is set, writes to the pin selection fields are ignored.
`ifndef PMX_DEFS_SVH
`define PMX_DEFS_SVH

// Register bus geometry.
`define PMX_ADDR_W 8
`define PMX_DATA_W 8
`define PMX_SEL_W 6
`define PMX_SRC_N 64

// Register map: one selection register per pin from the base, lock flag apart.
`define PMX_SEL_BASE 8'h00
`define PMX_LOCK_ADDR 8'h40
`define PMX_LOCK_BIT 0

// Reset values.
`define PMX_SEL_RESET 6'h00
`define PMX_LOCK_RESET 1'b0

// Source codes that have fixed meaning.
`define PMX_CODE_LATCH 6'h00
`define PMX_CODE_I2C1_SCL 6'h21
`define PMX_CODE_I2C1_SDA 6'h22
`define PMX_CODE_I2C2_SCL 6'h23
`define PMX_CODE_I2C2_SDA 6'h24

// Reserved code ranges, inclusive.
`define PMX_RSV_A_LO 6'h11
`define PMX_RSV_A_HI 6'h12
`define PMX_RSV_B_LO 6'h19
`define PMX_RSV_B_HI 6'h1B
`define PMX_RSV_C_LO 6'h33
`define PMX_RSV_C_HI 6'h3F

`endif

// File: logic/pmx_pkg.sv
`include "pmx_defs.svh"

package pmx_pkg;

    typedef logic [`PMX_SEL_W-1:0] pmx_code_t;

    // Named sources that the rest of the chip wires to fixed source slots.
    typedef enum logic [`PMX_SEL_W-1:0] {
        PMX_SRC_LATCH    = `PMX_CODE_LATCH,
        PMX_SRC_I2C1_SCL = `PMX_CODE_I2C1_SCL,
        PMX_SRC_I2C1_SDA = `PMX_CODE_I2C1_SDA,
        PMX_SRC_I2C2_SCL = `PMX_CODE_I2C2_SCL,
        PMX_SRC_I2C2_SDA = `PMX_CODE_I2C2_SDA
    } pmx_src_e;

    // A reserved code must never reach a peripheral slot.
    function automatic logic isReserved(input pmx_code_t code);
        isReserved = ((code >= `PMX_RSV_A_LO) && (code <= `PMX_RSV_A_HI)) ||
                     ((code >= `PMX_RSV_B_LO) && (code <= `PMX_RSV_B_HI)) ||
                     ((code >= `PMX_RSV_C_LO) && (code <= `PMX_RSV_C_HI));
    endfunction

endpackage

// File: logic/pmx_sel_reg.sv
`timescale 1ns/1ps
`include "pmx_defs.svh"

module pmx_sel_reg (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  wrEn,
    input  wire logic                  lockFlag,
    input  wire logic [`PMX_SEL_W-1:0] wrData,
    output logic      [`PMX_SEL_W-1:0] selQ
);

    // Only the power-on reset reaches this flop; soft resets are kept away on purpose.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selQ <= `PMX_SEL_RESET;
        end else if (wrEn && !lockFlag) begin
            selQ <= wrData;
        end
    end

endmodule // pmx_sel_reg

// File: logic/pmx_src_mux.sv
`timescale 1ns/1ps
`include "pmx_defs.svh"

module pmx_src_mux (
    input  wire logic                  [`PMX_SEL_W-1:0] selCode,
    input  wire logic                  [`PMX_SRC_N-1:0] periphSrc,
    input  wire logic                                   latchValue,
    output logic                                        pinOut
);

    // Pure gating, no flop: a registered pin would add a cycle of lag to every peripheral.
    always_comb begin
        if ((selCode == `PMX_CODE_LATCH) || pmx_pkg::isReserved(selCode)) begin
            pinOut = latchValue;
        end else begin
            pinOut = periphSrc[selCode];
        end
    end

endmodule // pmx_src_mux

// File: logic/pmx_pin_output_select.sv
`timescale 1ns/1ps
`include "pmx_defs.svh"

module pmx_pin_output_select #(
    parameter int NumPins = 8
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   sysResetReq,
    input  wire logic [`PMX_ADDR_W-1:0] regAddr,
    input  wire logic [`PMX_DATA_W-1:0] regWrData,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic      [`PMX_DATA_W-1:0] regRdData,
    input  wire logic [`PMX_SRC_N-1:0]  periphSrc,
    input  wire logic [NumPins-1:0]     pinLatch,
    output logic                        remapLocked,
    output logic      [NumPins-1:0]     pinOut
);

    // Pin i answers at the base plus i; everything from the end of that run up is not a selection.
    localparam logic [`PMX_ADDR_W-1:0] SelBase = `PMX_SEL_BASE;
    localparam logic [`PMX_ADDR_W-1:0] SelEnd  = `PMX_ADDR_W'(`PMX_SEL_BASE + NumPins);

    logic                   lockQ;
    logic                   lockD;
    logic [`PMX_DATA_W-1:0] rdDataQ;
    logic [`PMX_DATA_W-1:0] rdDataD;
    logic [NumPins-1:0]     selWrEn;
    pmx_pkg::pmx_code_t     selQ [NumPins];
    // Register strobes decoded once, shared by the lock logic and the checks.
    logic                   lockWrEn;
    logic                   lockRdEn;
    logic                   selRdEn;
    logic                   voidRdEn;

    // Address decode shared by the write enables and the read mux.
    function automatic logic isSelAddr(input logic [`PMX_ADDR_W-1:0] addr);
        isSelAddr = (addr >= SelBase) && (addr < SelEnd);
    endfunction

    function automatic logic hitsPin(input logic [`PMX_ADDR_W-1:0] addr, input int idx);
        hitsPin = isSelAddr(addr) && (addr == `PMX_ADDR_W'(`PMX_SEL_BASE + idx));
    endfunction

    // Named strobes for each register, so the checks read like the register map.
    assign lockWrEn = regWr && (regAddr == `PMX_LOCK_ADDR);
    assign lockRdEn = regRd && (regAddr == `PMX_LOCK_ADDR);
    assign selRdEn  = regRd && isSelAddr(regAddr);
    // An unmapped read still answers, with zero, so software never sees stale data there.
    assign voidRdEn = regRd && !isSelAddr(regAddr) && (regAddr != `PMX_LOCK_ADDR);

    // The lock flag clears on every reset, power-on and soft alike.
    always_comb begin
        lockD = lockQ;
        if (sysResetReq) begin
            lockD = `PMX_LOCK_RESET;
        end else if (lockWrEn) begin
            lockD = regWrData[`PMX_LOCK_BIT];
        end
    end

    // The lock flop itself; the power-on reset clears it just as the soft reset does.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockQ <= `PMX_LOCK_RESET;
        end else begin
            lockQ <= lockD;
        end
    end

    // The flag leaves the block straight from its flop, so it never glitches.
    assign remapLocked = lockQ;

    // Per-pin selection registers and source muxes.
    genvar gi;
    generate
        for (gi = 0; gi < NumPins; gi++) begin : gPin
            // The soft reset does not reach the selection; only writes do.
            assign selWrEn[gi] = regWr && hitsPin(regAddr, gi);

            pmx_sel_reg uSelReg (
                .clk      (clk),
                .rst_n    (rst_n),
                .wrEn     (selWrEn[gi]),
                .lockFlag (lockQ),
                .wrData   (regWrData[`PMX_SEL_W-1:0]),
                .selQ     (selQ[gi])
            );

            pmx_src_mux uSrcMux (
                .selCode    (selQ[gi]),
                .periphSrc  (periphSrc),
                .latchValue (pinLatch[gi]),
                .pinOut     (pinOut[gi])
            );
        end
    endgenerate

    // Read mux; unmapped addresses and unused bits return zero.
    always_comb begin
        rdDataD = '0;
        if (regRd) begin
            if (regAddr == `PMX_LOCK_ADDR) begin
                rdDataD[`PMX_LOCK_BIT] = lockQ;
            end else begin
                for (int i = 0; i < NumPins; i++) begin
                    if (hitsPin(regAddr, i)) begin
                        rdDataD = {2'h0, selQ[i]};
                    end
                end
            end
        end
    end

    // Read data stands only in the cycle after the strobe, so a stale value never lingers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdDataQ <= '0;
        end else begin
            rdDataQ <= rdDataD;
        end
    end

    // Read data come from a flop only.
    assign regRdData = rdDataQ;

    // Checks on each pin's register and output.
    generate
        for (gi = 0; gi < NumPins; gi++) begin : gChk
            selWrite_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                (regWr && hitsPin(regAddr, gi) && !lockQ)
                |=> (selQ[gi] == $past(regWrData[`PMX_SEL_W-1:0]))
            ) else $error("Selection did not take an unlocked write.");

            lockIgnore_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                (regWr && hitsPin(regAddr, gi) && lockQ) |=> $stable(selQ[gi])
            ) else $error("Selection changed while remapping was locked.");

            softKeep_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                (sysResetReq && !selWrEn[gi]) |=> $stable(selQ[gi])
            ) else $error("Soft reset disturbed a pin selection.");

            readBack_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                (regRd && hitsPin(regAddr, gi))
                |=> (regRdData == {2'h0, $past(selQ[gi])})
            ) else $error("Read data did not match the pin selection.");

            upperZero_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                $past(regRd) |-> (regRdData[`PMX_DATA_W-1:`PMX_SEL_W] == 2'h0)
            ) else $error("Unimplemented selection bits read as one.");

            i2cTwo_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                ((selQ[gi] == `PMX_CODE_I2C2_SDA) |-> (pinOut[gi] == periphSrc[`PMX_CODE_I2C2_SDA])) and
                ((selQ[gi] == `PMX_CODE_I2C2_SCL) |-> (pinOut[gi] == periphSrc[`PMX_CODE_I2C2_SCL]))
            ) else $error("Second two-wire interface not routed to pin.");

            i2cOne_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                ((selQ[gi] == `PMX_CODE_I2C1_SDA) |-> (pinOut[gi] == periphSrc[`PMX_CODE_I2C1_SDA])) and
                ((selQ[gi] == `PMX_CODE_I2C1_SCL) |-> (pinOut[gi] == periphSrc[`PMX_CODE_I2C1_SCL]))
            ) else $error("First two-wire interface not routed to pin.");

            latchPath_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                ((selQ[gi] == `PMX_CODE_LATCH) || pmx_pkg::isReserved(selQ[gi]))
                |-> (pinOut[gi] == pinLatch[gi])
            ) else $error("Latch or reserved code did not drive the latch value.");
        end
    endgenerate

    // Lock flag follows its own register and clears on soft reset.
    lockClear_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        sysResetReq |=> !remapLocked
    ) else $error("Lock flag survived a soft reset.");

    strobeOnly_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !$past(regRd) |-> (regRdData == '0)
    ) else $error("Read data stood outside the answer cycle.");

    // Software sets and clears the lock through its one live bit.
    lockWrite_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (lockWrEn && !sysResetReq)
        |=> (remapLocked == $past(regWrData[`PMX_LOCK_BIT]))
    ) else $error("Lock flag did not take its write.");

    // The lock holds between its own writes and resets.
    lockHold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!lockWrEn && !sysResetReq)
        |=> $stable(remapLocked)
    ) else $error("Lock flag changed without a write or reset.");

    // A soft reset beats a lock write in the same cycle.
    softLockWrite_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (sysResetReq && lockWrEn)
        |=> !remapLocked
    ) else $error("Lock write beat a soft reset.");

    // The lock register reads back its flag with zeros above it.
    lockRead_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        lockRdEn
        |=> (regRdData == {7'h00, $past(lockQ)})
    ) else $error("Lock register read back wrong.");

    // An address outside the map answers with zero.
    voidRead_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        voidRdEn
        |=> (regRdData == '0)
    ) else $error("Unmapped address returned data.");

    // Every selection read keeps the two unimplemented bits at zero.
    selRead_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        selRdEn
        |=> (regRdData[`PMX_DATA_W-1:`PMX_SEL_W] == 2'h0)
    ) else $error("Selection read showed an unimplemented bit.");

    // Power-on leaves the remapping unlocked.
    porLock_a: assert property (
        @(posedge clk)
        $rose(rst_n)
        |-> !remapLocked
    ) else $error("Lock flag set after power-on reset.");

    // Power-on leaves no read data standing.
    porRead_a: assert property (
        @(posedge clk)
        $rose(rst_n)
        |-> (regRdData == '0)
    ) else $error("Read data stood after power-on reset.");

    // Further checks per pin, each from a side the first set does not cover.
    generate
        for (gi = 0; gi < NumPins; gi++) begin : gChkMore
            // A selection moves only when its own register is written.
            selHold_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                !selWrEn[gi]
                |=> $stable(selQ[gi])
            ) else $error("Selection changed without a write to it.");

            // A soft reset in the cycle of an unlocked write lets the write land.
            softWrite_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                (sysResetReq && selWrEn[gi] && !lockQ)
                |=> (selQ[gi] == $past(regWrData[`PMX_SEL_W-1:0]))
            ) else $error("Write lost beside a soft reset.");

            // Power-on clears every selection.
            porSel_a: assert property (
                @(posedge clk)
                $rose(rst_n)
                |-> (selQ[gi] == `PMX_SEL_RESET)
            ) else $error("Selection not cleared by power-on reset.");

            // After power-on the pin shows its latch until software picks a source.
            porPin_a: assert property (
                @(posedge clk)
                $rose(rst_n)
                |-> (pinOut[gi] == pinLatch[gi])
            ) else $error("Pin did not show its latch after power-on reset.");

            // Any live code hands the pin to the peripheral slot of that number.
            periphPath_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                ((selQ[gi] != `PMX_CODE_LATCH) && !pmx_pkg::isReserved(selQ[gi]))
                |-> (pinOut[gi] == periphSrc[selQ[gi]])
            ) else $error("Live code did not route its peripheral to the pin.");

            // Writing a reserved code parks the pin on its latch in the next cycle.
            rsvWrite_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                (selWrEn[gi] && !lockQ && pmx_pkg::isReserved(regWrData[`PMX_SEL_W-1:0]))
                |=> (pinOut[gi] == pinLatch[gi])
            ) else $error("Reserved code did not park the pin on its latch.");

            // Writing code zero gives the pin back to its latch in the next cycle.
            latchWrite_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                (selWrEn[gi] && !lockQ && (regWrData[`PMX_SEL_W-1:0] == `PMX_CODE_LATCH))
                |=> (pinOut[gi] == pinLatch[gi])
            ) else $error("Code zero did not return the pin to its latch.");

            // A write to this pin's own address always raises its enable.
            wrDecode_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                (regWr && (regAddr == `PMX_ADDR_W'(`PMX_SEL_BASE + gi)))
                |-> selWrEn[gi]
            ) else $error("Write to a pin register missed its enable.");

            // A read of this pin's own address returns its selection.
            readAnswer_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                (regRd && (regAddr == `PMX_ADDR_W'(`PMX_SEL_BASE + gi)))
                |=> (regRdData[`PMX_SEL_W-1:0] == $past(selQ[gi]))
            ) else $error("Read of a pin register returned another value.");
        end
    endgenerate

endmodule // pmx_pin_output_select

// File: sim/pmx_periph_model.sv
`timescale 1ns/1ps
`include "pmx_defs.svh"

// Stands in for the peripheral outputs and port latches.
module pmx_periph_model #(
    parameter int NumPins = 8
) (
    input  wire logic                  clk,
    output logic      [`PMX_SRC_N-1:0] periphSrc,
    output logic      [NumPins-1:0]    pinLatch
);
    // Every line is redrawn at random each cycle, so a stale or wrong pick matches any one check only by a coin toss.
    initial begin
        periphSrc = '0;
        pinLatch = '0;
    end
    always @(posedge clk) begin
        periphSrc <= {$urandom, $urandom};
        pinLatch <= NumPins'($urandom);
    end
endmodule // pmx_periph_model

// File: sim/pmx_pin_output_select_test.sv
`timescale 1ns/1ps
`include "pmx_defs.svh"

module pmx_pin_output_select_test;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  sysResetReq = 1'b0;
    logic [7:0]            regAddr = 8'h00;
    logic [7:0]            regWrData = 8'h00;
    logic                  regWr = 1'b0;
    logic                  regRd = 1'b0;
    logic                  rdSeen = 1'b0;
    logic [7:0]            regRdData;
    logic [`PMX_SRC_N-1:0] periphSrc;
    logic [7:0]            pinLatch;
    logic                  remapLocked;
    logic [7:0]            pinOut;
    logic [7:0]            expQ[$];
    logic [7:0]            rnd;
    int                    errorCnt = 0;
    int                    checkCount = 0;
    int                    cycles = 0;

    // Half period of 25 ns gives the 20 MHz clock.
    always #25 clk = ~clk;

    pmx_pin_output_select #(.NumPins(8)) i_pmx_pin_output_select (.clk(clk), .rst_n(rst_n),
        .sysResetReq(sysResetReq), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .periphSrc(periphSrc), .pinLatch(pinLatch),
        .remapLocked(remapLocked), .pinOut(pinOut));
    pmx_periph_model #(.NumPins(8)) i_pmx_periph_model (.clk(clk), .periphSrc(periphSrc),
        .pinLatch(pinLatch));

    task automatic results();
        $display("checks=%0d errors=%0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One compare per kind of result, so a failure line says which kind slipped.
    task automatic cmpRd(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] t=%0t read got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpPin(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpLock(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] t=%0t lock got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // The note goes on the queue with the strobe; the watcher takes it two edges later.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
    endtask

    // Code zero and the reserved ranges fall back to the port latch.
    task automatic pin(input int i, input logic [5:0] c);
        logic e;
        @(negedge clk);
        e = periphSrc[c];
        if (c == 6'h00 || (c >= 6'h11 && c <= 6'h12) || (c >= 6'h19 && c <= 6'h1B) || c >= 6'h33)
            e = pinLatch[i];
        cmpPin(pinOut[i], e);
    endtask

    // Read data stand only in the cycle after the strobe, so they are judged there.
    always @(posedge clk) begin
        rdSeen <= regRd;
        if (rdSeen)
            cmpRd(regRdData, expQ.pop_front());
    end

    // The run needs well under 1000 cycles; the ceiling catches a hang.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errorCnt++;
            results();
        end
    end

    initial begin
        rnd = 8'($urandom(77));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(8'(i), 8'h00);
            pin(i, 6'h00);
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'(i), 8'hC0 | (8'h24 - 8'(i)));
            rd(8'(i), 8'h24 - 8'(i));
            pin(i, 6'h24 - 6'(i));
        end
        repeat (40) begin
            rnd = 8'($urandom);
            wr(8'h07, rnd);
            pin(7, rnd[5:0]);
            rd(8'h07, rnd & 8'h3F);
        end
        rd(8'h20, 8'h00);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h01);
        wr(8'h00, 8'h05);
        rd(8'h00, 8'h24);
        pin(0, 6'h24);
        cmpLock(remapLocked, 1'b1);
        @(posedge clk);
        sysResetReq <= 1'b1;
        @(posedge clk);
        sysResetReq <= 1'b0;
        rd(8'h40, 8'h00);
        rd(8'h01, 8'h23);
        wr(8'h00, 8'h05);
        rd(8'h00, 8'h05);
        wr(8'h40, 8'h01);
        wr(8'h40, 8'hFE);
        rd(8'h40, 8'h00);
        wr(8'h02, 8'h1F);
        rd(8'h02, 8'h1F);
        pin(2, 6'h1F);
        wr(8'h02, 8'h40);
        pin(2, 6'h00);
        // A write that meets a soft reset still lands, since only power-on clears a selection.
        @(posedge clk);
        sysResetReq <= 1'b1;
        regWr <= 1'b1;
        regAddr <= 8'h05;
        regWrData <= 8'h2A;
        @(posedge clk);
        sysResetReq <= 1'b0;
        regWr <= 1'b0;
        rd(8'h05, 8'h2A);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 8'h00);
        rd(8'h03, 8'h00);
        pin(3, 6'h00);
        cmpLock(remapLocked, 1'b0);
        repeat (3) @(posedge clk);
        results();
    end
endmodule // pmx_pin_output_select_test
